// file: design/ifs_bank3.sv
// Purpose: Third interrupt flag status bank with AXI4-Lite slave
// Assumes: Request inputs are pulses or levels on aclk; no synchroniser
// Notes:   Flags are set by hardware and also written by software
// Operation
// - Calendar clock request sets bit 14
// - DMA channel 5 done sets bit 13
// - Codec event request sets bit 12
// - Codec error request sets bit 11
// - Bits 15 and 10-0 read zero
`timescale 1ns/1ps
module ifs_bank3
    import ifs_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  calendar_clock_req,
    input  wire logic                  dma_channel5_done_req,
    input  wire logic                  codec_event_req,
    input  wire logic                  codec_error_req,
    input  wire logic [IFS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [IFS_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [15:0]                interrupt_flag_status_3,
    output logic                       irq
);
    logic [15:0]           events;          // Sticky copy for interrupt use
    logic [15:0]           mask;            // Interrupt enable per bit
    logic [15:0]           next_flags;
    logic [15:0]           next_events;
    logic [15:0]           next_mask;
    logic                  next_irq;
    logic [15:0]           req_vec;         // Hardware set terms
    logic                  aw_held;         // Write address taken
    logic                  w_held;          // Write data taken
    logic [IFS_ADDR_W-1:0] aw_q;
    logic [31:0]           w_q;
    logic [3:0]            ws_q;
    logic                  next_aw_held;
    logic                  next_w_held;
    logic [IFS_ADDR_W-1:0] next_aw_q;
    logic [31:0]           next_w_q;
    logic [3:0]            next_ws_q;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    logic                  next_rvalid;
    logic [31:0]           next_rdata;
    logic [1:0]            next_rresp;
    logic                  wr_fire;         // Both halves present
    logic [15:0]           wr_val;          // Write data after byte lanes

    // Merge low two byte lanes into the new value
    function automatic logic [15:0] ifs_lanes(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0]  s);
        logic [15:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // Map the four requests onto their flag positions
    always_comb begin
        req_vec               = 16'h0000;
        req_vec[IFS_BIT_RTC]  = calendar_clock_req;
        req_vec[IFS_BIT_DMA5] = dma_channel5_done_req;
        req_vec[IFS_BIT_CEV]  = codec_event_req;
        req_vec[IFS_BIT_CERR] = codec_error_req;
    end

    // Write channel capture; awready and wready drop once each is held
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_q    = aw_q;
        next_w_q     = w_q;
        next_ws_q    = ws_q;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_q    = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_q    = s_axi_wdata;
            next_ws_q   = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
        end
    end

    // Response only issues when no earlier one waits
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    // Register state update; hardware set beats software clear
    always_comb begin
        next_flags  = interrupt_flag_status_3;
        next_events = events;
        next_mask   = mask;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp  = s_axi_bresp;
        wr_val      = 16'h0000;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp  = IFS_RESP_OKAY;
            unique case (aw_q)
                IFS_OFS_FLAGS: begin
                    wr_val     = ifs_lanes(interrupt_flag_status_3, w_q, ws_q);
                    next_flags = wr_val;
                end
                IFS_OFS_MASK: begin
                    next_mask = ifs_lanes(mask, w_q, ws_q);
                end
                IFS_OFS_EVENTS: begin
                    // Write one to clear
                    wr_val      = ifs_lanes(16'h0000, w_q, ws_q);
                    next_events = events & ~wr_val;
                end
                default: begin
                    next_bresp = IFS_RESP_SLV;                 // Unmapped
                end
            endcase
        end
        next_flags  = (next_flags | req_vec) & IFS_IMPL_MASK;
        next_events = (next_events | req_vec) & IFS_IMPL_MASK;
        next_mask   = next_mask & IFS_IMPL_MASK;
        next_irq    = |(next_events & next_mask);
    end

    // Read channel; single read outstanding, one cycle answer
    always_comb begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = IFS_RESP_OKAY;
            unique case (s_axi_araddr)
                IFS_OFS_FLAGS:  next_rdata = {16'h0000,
                                    interrupt_flag_status_3};
                IFS_OFS_MASK:   next_rdata = {16'h0000, mask};
                IFS_OFS_EVENTS: next_rdata = {16'h0000, events};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = IFS_RESP_SLV;
                end
            endcase
        end
    end

    // Register everything; reset clears flags to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_flag_status_3 <= IFS_RST_FLAGS;
            events        <= IFS_RST_FLAGS;
            mask          <= IFS_RST_MASK;
            irq           <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_q          <= '0;
            w_q           <= 32'h0000_0000;
            ws_q          <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= IFS_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= IFS_RESP_OKAY;
        end else begin
            interrupt_flag_status_3 <= next_flags;
            events        <= next_events;
            mask          <= next_mask;
            irq           <= next_irq;
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_q          <= next_aw_q;
            w_q           <= next_w_q;
            ws_q          <= next_ws_q;
            s_axi_awready <= !next_aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !next_w_held && !(s_axi_wvalid && s_axi_wready);
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // A calendar request shows in the flag one edge later
    property p_rtc_set;
        @(posedge aclk) disable iff (!aresetn)
        calendar_clock_req |=> interrupt_flag_status_3[IFS_BIT_RTC];
    endproperty
    a_rtc_set: assert property (p_rtc_set)
        else $error("calendar flag not set");

    property p_dma_set;
        @(posedge aclk) disable iff (!aresetn)
        dma_channel5_done_req |=> interrupt_flag_status_3[IFS_BIT_DMA5];
    endproperty
    a_dma_set: assert property (p_dma_set)
        else $error("dma5 flag not set");

    property p_cev_set;
        @(posedge aclk) disable iff (!aresetn)
        codec_event_req |=> interrupt_flag_status_3[IFS_BIT_CEV];
    endproperty
    a_cev_set: assert property (p_cev_set)
        else $error("codec event flag not set");

    property p_cerr_set;
        @(posedge aclk) disable iff (!aresetn)
        codec_error_req |=> interrupt_flag_status_3[IFS_BIT_CERR];
    endproperty
    a_cerr_set: assert property (p_cerr_set)
        else $error("codec error flag not set");

    property p_unimpl_zero;
        @(posedge aclk) disable iff (!aresetn)
        (interrupt_flag_status_3 & ~IFS_IMPL_MASK) == 16'h0000
        && (!s_axi_rvalid || s_axi_rdata[31:15] == 17'h00000);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bits nonzero");

    property p_sticky;
        @(posedge aclk) disable iff (!aresetn)
        (interrupt_flag_status_3[IFS_BIT_RTC] && !wr_fire)
        |=> interrupt_flag_status_3[IFS_BIT_RTC];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without write");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        ##1 irq == |($past(next_events) & $past(next_mask));
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq mismatch");

    property p_read_answer;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read not answered");
endmodule

// file: design/ifs_pkg.sv
// Purpose: Constants for the third interrupt flag status bank
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Flag register holds 16 bits in the low half of the word
package ifs_pkg;
    localparam int          IFS_DATA_W     = 32;           // Bus data width
    localparam int          IFS_ADDR_W     = 4;            // Byte address bits
    localparam int          IFS_FLAG_W     = 16;           // Flag register width
    localparam logic [3:0]  IFS_OFS_FLAGS  = 4'h0;         // Flag status
    localparam logic [3:0]  IFS_OFS_MASK   = 4'h4;         // Interrupt mask
    localparam logic [3:0]  IFS_OFS_EVENTS = 4'h8;         // Sticky events
    localparam int          IFS_BIT_RTC    = 14;           // Calendar clock
    localparam int          IFS_BIT_DMA5   = 13;           // DMA channel 5
    localparam int          IFS_BIT_CEV    = 12;           // Codec event
    localparam int          IFS_BIT_CERR   = 11;           // Codec error
    localparam logic [15:0] IFS_IMPL_MASK  = 16'h7800;     // Implemented bits
    localparam logic [15:0] IFS_RST_FLAGS  = 16'h0000;     // Flags after reset
    localparam logic [15:0] IFS_RST_MASK   = 16'h0000;     // Mask after reset
    localparam logic [1:0]  IFS_RESP_OKAY  = 2'h0;         // AXI OKAY
    localparam logic [1:0]  IFS_RESP_SLV   = 2'h2;         // AXI SLVERR
endpackage

// file: sim/ifs_bank3_tb_top.sv
// Purpose: Self-checking bench for the third flag status bank
// Assumes: Waits end on the answer; only the watchdog ends a hang
// Notes:   Requests are one-cycle pulses on aclk; no random stimulus
`timescale 1ns/1ps
module ifs_bank3_tb_top;
    import ifs_pkg::*;
    logic        aclk;                 // 25 MHz system clock
    logic        aresetn  = 1'b0;      // Sync reset, active low
    logic [3:0]  req      = 4'h0;      // Requests: rtc, dma5, event, error
    logic [3:0]  awaddr   = 4'h0;      // Write address
    logic        awvalid  = 1'b0;      // Write address valid
    logic        awready;              // Write address ready
    logic [31:0] wdata    = 32'h0;     // Write data
    logic        wvalid   = 1'b0;      // Write data valid
    logic        wready;               // Write data ready
    logic [1:0]  bresp;                // Write response
    logic        bvalid;               // Write response valid
    logic        bready   = 1'b0;      // Write response ready
    logic [3:0]  araddr   = 4'h0;      // Read address
    logic        arvalid  = 1'b0;      // Read address valid
    logic        arready;              // Read address ready
    logic [31:0] rdata;                // Read data
    logic [1:0]  rresp;                // Read response
    logic        rvalid;               // Read data valid
    logic        rready   = 1'b0;      // Read data ready
    logic [15:0] flags;                // Flag register output
    logic        irq;                  // Level interrupt
    int          fail_count = 0;       // Mismatches seen
    int          tests_run  = 0;       // Comparisons made
    logic [31:0] rd;                   // Last read data
    logic [1:0]  rs;                   // Last response code

    ifs_bank3 DUT (.aclk(aclk), .aresetn(aresetn),
        .calendar_clock_req(req[3]), .dma_channel5_done_req(req[2]),
        .codec_event_req(req[1]), .codec_error_req(req[0]),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .interrupt_flag_status_3(flags), .irq(irq));

    // Free-running clock, 40 ns period
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Compare one value, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h", $time, msg, got);
        end
    endtask

    // Write one word; AW and W are released each at its own handshake
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        int n;
        aw = 0;
        w = 0;
        n = 0;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            n++;
            if (!aw && awready === 1'b1) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        // Response can only come after both are taken
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
        // Let an edge pass so the next call never rewrites bready now
        @(posedge aclk);
        chk(n < 50, 1, "write latency");
    endtask

    // Read one word; data and response taken at the rvalid edge
    task automatic rdw(input logic [3:0] a);
        int n;
        n = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        // Let an edge pass so the next call never rewrites rready now
        @(posedge aclk);
        chk(n < 50, 1, "read latency");
    endtask

    // One-cycle request pulse, then let the set land
    task automatic pulse(input logic [3:0] r);
        req <= r;
        @(posedge aclk);
        req <= 4'h0;
        repeat (3) @(posedge aclk);
    endtask

    // Everything clear after reset
    task automatic t_reset();
        rdw(IFS_OFS_FLAGS); chk(rd, 32'h0, "flags reset");
        chk(rs, IFS_RESP_OKAY, "read resp okay");
        rdw(IFS_OFS_MASK); chk(rd, 32'h0, "mask reset");
        rdw(IFS_OFS_EVENTS); chk(rd, 32'h0, "events reset");
        chk(irq, 1'b0, "irq reset");
        $display("test reset done");
    endtask

    // Each source sets only its own bit, and the bit stays set
    task automatic t_sources();
        for (int i = 0; i < 4; i++) begin
            wr(IFS_OFS_FLAGS, 32'h0);
            pulse(4'h1 << i);
            rdw(IFS_OFS_FLAGS);
            chk(rd, 32'h800 << i, "source bit");
            chk(flags, 16'h0800 << i, "flag port");
        end
        chk(irq, 1'b0, "irq with mask clear");
        wr(IFS_OFS_EVENTS, 32'h7800);
        $display("test sources done");
    endtask

    // Software writes: unimplemented bits drop, zero clears
    task automatic t_write();
        wr(IFS_OFS_FLAGS, 32'hFFFFFFFF);
        chk(rs, IFS_RESP_OKAY, "write resp okay");
        rdw(IFS_OFS_FLAGS); chk(rd, 32'h7800, "all ones");
        wr(IFS_OFS_FLAGS, 32'h87FF);
        rdw(IFS_OFS_FLAGS); chk(rd, 32'h0, "unimpl only");
        $display("test write done");
    endtask

    // Unmasked event raises irq; write one clears it; masked stays low
    task automatic t_irq();
        wr(IFS_OFS_MASK, 32'h2000);
        pulse(4'h2);
        chk(irq, 1'b0, "masked event");
        pulse(4'h4);
        chk(irq, 1'b1, "unmasked event");
        rdw(IFS_OFS_EVENTS); chk(rd, 32'h3000, "events");
        wr(IFS_OFS_EVENTS, 32'h3000);
        @(posedge aclk);
        chk(irq, 1'b0, "irq after clear");
        $display("test irq done");
    endtask

    // Unmapped offset answers with an error and reads zero
    task automatic t_unmapped();
        wr(4'hC, 32'hFFFF); chk(rs, IFS_RESP_SLV, "write resp");
        rdw(4'hC); chk(rs, IFS_RESP_SLV, "read resp");
        chk(rd, 32'h0, "read data");
        $display("test unmapped done");
    endtask

    // Counts, verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_sources();
        t_write();
        t_irq();
        t_unmapped();
        final_report();
    end

    // Watchdog; whole run needs well under 1000 cycles
    initial begin
        #200us;
        fail_count++;
        final_report();
    end
endmodule
